// ### design/pll_lock_status_irq.v
// PLL enable, lock status, lock edge flags and interrupt logic behind an AHB-Lite slave.
`include "pll_ctl_defines.vh"

module pll_lock_status_irq #(
  parameter SYNC_DEPTH = `SYNC_STAGES
) (
  // Clock, reset and clock enable
  input wire clk_sys,
  input wire arst_n,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // PLL analogue side
  input wire pll_lock_async,
  output wire pll_enable,
  output wire [1:0] charge_pump_sel,
  output wire [1:0] lock_sensitivity_sel,
  // Clock generator side
  output wire [1:0] sys_clock_source_select,
  output wire pll_irq
);

  // Bus data-phase state.
  reg wr_pend_r;
  reg rd_pend_r;
  reg [9:0] dp_idx_r;
  reg dp_hit_r;
  reg [31:0] hrdata_r;

  // Register state.
  reg [1:0] pump_r;
  reg [1:0] sense_r;
  reg [1:0] src_r;
  reg pll_en_r;
  reg lock_flag_r;
  reg unlock_flag_r;
  reg lock_ie_r;
  reg unlock_ie_r;
  reg [`IRQ_WIDTH-1:0] irq_stat_r;
  reg [`IRQ_WIDTH-1:0] irq_mask_r;

  // Next values.
  reg [1:0] pump_nxt;
  reg [1:0] sense_nxt;
  reg [1:0] src_nxt;
  reg pll_en_nxt;
  reg lock_ie_nxt;
  reg unlock_ie_nxt;
  reg refused;
  reg [31:0] rd_value;
  reg wr_pend_nxt;
  reg rd_pend_nxt;
  reg [9:0] dp_idx_nxt;
  reg dp_hit_nxt;
  reg [31:0] hrdata_nxt;
  reg lock_flag_nxt;
  reg unlock_flag_nxt;
  reg [`IRQ_WIDTH-1:0] irq_stat_nxt;
  reg [`IRQ_WIDTH-1:0] irq_mask_nxt;

  wire lock_level;
  wire lock_rise;
  wire lock_fall;
  wire accept;
  wire addr_ok;
  wire wr_cfg;
  wire wr_ctl;
  wire wr_stat;
  wire wr_mask;
  wire rd_ctl;
  wire [7:0] cfg_value;
  wire [7:0] ctl_value;
  wire [`IRQ_WIDTH-1:0] irq_events;
  wire pll_ready;
  wire src_is_pll;

  lock_sync #(
    .STAGES(SYNC_DEPTH)
  ) u_lock_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .level_async(pll_lock_async),
    .level_sync(lock_level),
    .rise_pulse(lock_rise),
    .fall_pulse(lock_fall)
  );

  // Reads take one wait state so that the returned word and the clearing of
  // the edge flags happen on the same edge; a flag can never be lost between them.
  assign hreadyout = ce & ~rd_pend_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  assign accept = hsel & hready & htrans[1] & ce;
  assign addr_ok = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0);
  assign pll_ready = pll_en_r & lock_level;
  assign src_is_pll = (src_r == `SRC_PLL);

  // A stalled data phase keeps its address so the read mux stays steady.
  always @* begin
    wr_pend_nxt = 1'b0;
    rd_pend_nxt = 1'b0;
    dp_idx_nxt = dp_idx_r;
    dp_hit_nxt = dp_hit_r;
    if (hready) begin
      wr_pend_nxt = accept & hwrite;
      rd_pend_nxt = accept & ~hwrite;
      dp_idx_nxt = haddr[11:2];
      dp_hit_nxt = accept & addr_ok;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      dp_idx_r <= 10'h000;
      dp_hit_r <= 1'b0;
    end else if (ce) begin
      wr_pend_r <= wr_pend_nxt;
      rd_pend_r <= rd_pend_nxt;
      dp_idx_r <= dp_idx_nxt;
      dp_hit_r <= dp_hit_nxt;
    end
  end

  // Unmapped addresses read zero and ignore writes, with an OKAY response.
  assign wr_cfg = ce & wr_pend_r & dp_hit_r & (dp_idx_r == `IDX_LOOP_CONFIG);
  assign wr_ctl = ce & wr_pend_r & dp_hit_r & (dp_idx_r == `IDX_ENABLE_STATUS);
  assign wr_stat = ce & wr_pend_r & dp_hit_r & (dp_idx_r == `IDX_IRQ_STATUS);
  assign wr_mask = ce & wr_pend_r & dp_hit_r & (dp_idx_r == `IDX_IRQ_MASK);
  assign rd_ctl = ce & rd_pend_r & dp_hit_r & (dp_idx_r == `IDX_ENABLE_STATUS);

  assign cfg_value = {pump_r, 2'b00, sense_r, src_r};
  assign ctl_value = {2'b00, lock_level, lock_flag_r, unlock_flag_r,
                      lock_ie_r, unlock_ie_r, pll_en_r};

  // Read mux.
  always @* begin
    rd_value = 32'h00000000;
    if (dp_hit_r) begin
      case (dp_idx_r)
        `IDX_LOOP_CONFIG: rd_value = {24'h000000, cfg_value};
        `IDX_ENABLE_STATUS: rd_value = {24'h000000, ctl_value};
        `IDX_IRQ_STATUS: rd_value = {29'h0, irq_stat_r};
        `IDX_IRQ_MASK: rd_value = {29'h0, irq_mask_r};
        default: rd_value = 32'h00000000;
      endcase
    end
  end

  always @* begin
    hrdata_nxt = hrdata_r;
    if (rd_pend_r) begin
      hrdata_nxt = rd_value;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hrdata_r <= 32'h00000000;
    end else if (ce) begin
      hrdata_r <= hrdata_nxt;
    end
  end

  // Writes to the loop configuration register.
  always @* begin
    pump_nxt = pump_r;
    sense_nxt = sense_r;
    src_nxt = src_r;
    refused = 1'b0;
    if (wr_cfg) begin
      // Analogue settings are frozen while the PLL runs, so a careless write
      // cannot disturb a loop that may be clocking the system.
      if (!pll_en_r) begin
        pump_nxt = hwdata[`CFG_PUMP_HI:`CFG_PUMP_LO];
        sense_nxt = hwdata[`CFG_SENSE_HI:`CFG_SENSE_LO];
      end
      case (hwdata[`CFG_SRC_HI:`CFG_SRC_LO])
        `SRC_PLL: begin
          if (pll_ready) begin
            src_nxt = `SRC_PLL;
          end else begin
            refused = 1'b1;
          end
        end
        `SRC_XTAL: src_nxt = `SRC_XTAL;
        `SRC_RTC: src_nxt = `SRC_RTC;
        default: src_nxt = src_r;
      endcase
    end
  end

  // Writes to the enable and status register.
  always @* begin
    pll_en_nxt = pll_en_r;
    lock_ie_nxt = lock_ie_r;
    unlock_ie_nxt = unlock_ie_r;
    if (wr_ctl) begin
      lock_ie_nxt = hwdata[`CTL_LOCK_IE];
      unlock_ie_nxt = hwdata[`CTL_UNLOCK_IE];
      if (hwdata[`CTL_PLL_EN] || !src_is_pll) begin
        pll_en_nxt = hwdata[`CTL_PLL_EN];
      end
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pump_r <= 2'h0;
      sense_r <= 2'h0;
      src_r <= `SRC_XTAL;
      pll_en_r <= 1'b0;
      lock_ie_r <= 1'b0;
      unlock_ie_r <= 1'b0;
    end else if (ce) begin
      pump_r <= pump_nxt;
      sense_r <= sense_nxt;
      src_r <= src_nxt;
      pll_en_r <= pll_en_nxt;
      lock_ie_r <= lock_ie_nxt;
      unlock_ie_r <= unlock_ie_nxt;
    end
  end

  // Edge flags: a new edge on the clearing read wins, so no event is lost.
  always @* begin
    lock_flag_nxt = lock_flag_r;
    unlock_flag_nxt = unlock_flag_r;
    if (rd_ctl) begin
      lock_flag_nxt = 1'b0;
      unlock_flag_nxt = 1'b0;
    end
    if (lock_rise) begin
      lock_flag_nxt = 1'b1;
    end
    if (lock_fall) begin
      unlock_flag_nxt = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lock_flag_r <= 1'b0;
      unlock_flag_r <= 1'b0;
    end else if (ce) begin
      lock_flag_r <= lock_flag_nxt;
      unlock_flag_r <= unlock_flag_nxt;
    end
  end

  // Sticky event status, cleared by writing one; a new event wins over the clear.
  assign irq_events = {refused, lock_fall, lock_rise};

  always @* begin
    irq_stat_nxt = irq_stat_r | irq_events;
    irq_mask_nxt = irq_mask_r;
    if (wr_stat) begin
      irq_stat_nxt = (irq_stat_r & ~hwdata[`IRQ_WIDTH-1:0]) | irq_events;
    end
    if (wr_mask) begin
      irq_mask_nxt = hwdata[`IRQ_WIDTH-1:0];
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_r <= `IRQ_RESET;
      irq_mask_r <= `IRQ_RESET;
    end else if (ce) begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  assign pll_irq = (lock_flag_r & lock_ie_r) | (unlock_flag_r & unlock_ie_r)
                   | (|(irq_stat_r & irq_mask_r));

  assign pll_enable = pll_en_r;
  assign charge_pump_sel = pump_r;
  assign lock_sensitivity_sel = sense_r;
  assign sys_clock_source_select = src_r;

endmodule // pll_lock_status_irq

// ### design/pll_ctl_defines.vh
// Register offsets, field positions and reset values of the PLL control and status block.
`ifndef PLL_CTL_DEFINES_VH
`define PLL_CTL_DEFINES_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_LOOP_CONFIG 10'h05E
`define IDX_ENABLE_STATUS 10'h05F
`define IDX_IRQ_STATUS 10'h060
`define IDX_IRQ_MASK 10'h061

// Fields of loop_config_register.
`define CFG_PUMP_HI 7
`define CFG_PUMP_LO 6
`define CFG_SENSE_HI 3
`define CFG_SENSE_LO 2
`define CFG_SRC_HI 1
`define CFG_SRC_LO 0
`define CFG_RESET 8'h00

// Encodings of the system clock source select.
`define SRC_XTAL 2'h0
`define SRC_PLL 2'h1
`define SRC_RTC 2'h2
`define SRC_RSVD 2'h3

// Fields of loop_enable_status_register.
`define CTL_LOCK_STATUS 5
`define CTL_LOCK_FLAG 4
`define CTL_UNLOCK_FLAG 3
`define CTL_LOCK_IE 2
`define CTL_UNLOCK_IE 1
`define CTL_PLL_EN 0
`define CTL_RESET 8'h00

// Fields of the interrupt status and mask registers.
`define IRQ_LOCK 0
`define IRQ_UNLOCK 1
`define IRQ_REFUSED 2
`define IRQ_WIDTH 3
`define IRQ_RESET 3'h0

// Synchronizer depth.
`define SYNC_STAGES 2

`endif

// ### design/lock_sync.v
// Synchronizer and edge detector for an asynchronous level.
module lock_sync #(
  parameter STAGES = 2
) (
  // Clock, reset and enable
  input wire clk_sys,
  input wire arst_n,
  input wire ce,
  // Asynchronous level in
  input wire level_async,
  // Synchronized level and edges
  output wire level_sync,
  output wire rise_pulse,
  output wire fall_pulse
);

  reg [STAGES-1:0] chain_r;
  reg prev_r;

  // The first stage feeds only the next stage; all decisions use the last stage.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      chain_r <= {STAGES{1'b0}};
      prev_r <= 1'b0;
    end else if (ce) begin
      chain_r <= {chain_r[STAGES-2:0], level_async};
      prev_r <= chain_r[STAGES-1];
    end
  end

  assign level_sync = chain_r[STAGES-1];
  assign rise_pulse = ce & chain_r[STAGES-1] & ~prev_r;
  assign fall_pulse = ce & ~chain_r[STAGES-1] & prev_r;

endmodule // lock_sync

// ### test/pll_lock_status_irq_asserts.sv
// Port checker for the PLL lock status and interrupt block.
module pll_lock_status_irq_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Bus
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  // PLL and clock generator
  input wire logic pll_lock_async,
  input wire logic pll_enable,
  input wire logic [1:0] sys_clock_source_select,
  input wire logic pll_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic acc;
  logic [2:0] since_lock_r;
  assign acc = ce && hsel && htrans[1] && hreadyout;
  // Saturating age of the last lock change, so an irq rise can be traced to it.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      since_lock_r <= 3'h7;
    else if ($changed(pll_lock_async))
      since_lock_r <= 3'h0;
    else if (since_lock_r != 3'h7)
      since_lock_r <= since_lock_r + 3'h1;
  end
  chk_src_needs_en: assert property (sys_clock_source_select == 2'h1 |-> pll_enable)
    else $error("PLL selected while disabled");
  chk_en_held: assert property ($past(sys_clock_source_select) == 2'h1 |-> pll_enable)
    else $error("PLL enable cleared while selected");
  chk_en_by_write: assert property ($changed(pll_enable) |-> $past(acc && hwrite, 2))
    else $error("PLL enable changed without a write");
  chk_src_by_write: assert property ($changed(sys_clock_source_select) |-> $past(acc && hwrite, 2))
    else $error("Clock source changed without a write");
  chk_irq_cause: assert property ($rose(pll_irq) |-> since_lock_r <= 3'h3 || $past(acc && hwrite, 2))
    else $error("Interrupt rose without a lock edge or write");
  chk_irq_clear: assert property ($fell(pll_irq) |-> $past(acc, 2))
    else $error("Interrupt fell without a bus access");
  chk_read_wait: assert property (acc && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state not one cycle");
  chk_write_fast: assert property (acc && hwrite |=> hreadyout)
    else $error("Write data phase stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("Response not OKAY");
endmodule // pll_lock_status_irq_asserts

bind pll_lock_status_irq pll_lock_status_irq_asserts u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
  .pll_lock_async(pll_lock_async), .pll_enable(pll_enable),
  .sys_clock_source_select(sys_clock_source_select), .pll_irq(pll_irq));

// ### test/pll_lock_status_irq_test.sv
// Self-checking testbench for the PLL lock status and interrupt block.
module pll_lock_status_irq_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] CFG = 32'h178, CTL = 32'h17C, STS = 32'h180, MSK = 32'h184;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic lock = 1'b0;
  logic rd_pend = 1'b0;
  logic [31:0] rnd = 32'h8E20;
  logic [31:0] exp_q[$];
  int fails = 0;
  int check_count = 0;
  wire hreadyout, hresp, pll_enable, pll_irq;
  wire [31:0] hrdata;
  wire [1:0] src, pump, sense;
  pll_lock_status_irq dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pll_lock_async(lock), .pll_enable(pll_enable), .charge_pump_sel(pump),
    .lock_sensitivity_sel(sense), .sys_clock_source_select(src), .pll_irq(pll_irq));
  always #10 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Each phase is held until ready is seen high at a rising edge, never on a falling one.
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    if (!wr)
      exp_q.push_back(d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
  endtask
  task pause(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task set_lock(input logic v);
    @(posedge clk_sys);
    lock <= v;
    pause(4);
  endtask
  task wrap_up;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (rd_pend && hreadyout)
      chk("hrdata", exp_q.pop_front(), hrdata);
    if (hreadyout)
      rd_pend <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    bus(0, CTL, 32'h0);
    bus(0, CFG, 32'h0);
    bus(1, CFG, 32'hCC);
    bus(0, CFG, 32'hCC);
    chk("pump", 3, pump);
    chk("sense", 3, sense);
    set_lock(1);
    bus(0, CTL, 32'h30);
    bus(0, CTL, 32'h20);
    bus(1, CTL, 32'h07);
    bus(0, CTL, 32'h27);
    set_lock(0);
    chk("pll_irq", 1, pll_irq);
    bus(0, CTL, 32'h0F);
    pause(1);
    chk("pll_irq", 0, pll_irq);
    bus(1, CTL, 32'h23);
    set_lock(1);
    chk("pll_irq", 0, pll_irq);
    bus(0, CTL, 32'h33);
    bus(1, MSK, 32'h1);
    pause(1);
    chk("pll_irq", 1, pll_irq);
    bus(1, STS, 32'h3);
    pause(1);
    chk("pll_irq", 0, pll_irq);
    set_lock(0);
    bus(1, CFG, 32'h1);
    pause(1);
    chk("src", 0, src);
    bus(0, STS, 32'h6);
    set_lock(1);
    bus(1, CFG, 32'h1);
    bus(1, CTL, 32'h0);
    pause(1);
    chk("src", 1, src);
    chk("pll_enable", 1, pll_enable);
    bus(0, CFG, 32'hCD);
    chk("pump", 3, pump);
    bus(0, CTL, 32'h39);
    bus(1, CFG, 32'h0);
    bus(1, CTL, 32'h0);
    pause(1);
    chk("pll_enable", 0, pll_enable);
    repeat (3) begin
      rnd = xs(rnd);
      bus(1, MSK, rnd);
      bus(0, MSK, rnd & 32'h7);
      bus(1, 32'h200, rnd);
      bus(0, 32'h200, 32'h0);
    end
    @(posedge clk_sys);
    ce <= 1'b0;
    pause(2);
    chk("hreadyout", 0, hreadyout);
    @(posedge clk_sys);
    ce <= 1'b1;
    bus(0, CTL, 32'h20);
    pause(2);
    wrap_up();
  end
endmodule // pll_lock_status_irq_test
